// File: verilog/sfshp_pkg.sv
// shared constants and types of the serial flash front end
package sfshp_pkg;

  // byte framing
  localparam int           BYTE_W      = 8;
  localparam int           ADDR_W      = 24;
  localparam logic [2:0]   BIT_FIRST   = 3'h0;
  localparam logic [2:0]   BIT_LAST    = 3'h7;
  localparam logic [2:0]   BC_OPCODE   = 3'h0;
  localparam logic [2:0]   BC_DATA1    = 3'h1;
  localparam logic [2:0]   BC_ADDR_END = 3'h3;
  localparam logic [2:0]   BC_MAX      = 3'h7;

  // status register layout
  localparam int           SR_LVL_LO   = 2;
  localparam int           SR_LVL_HI   = 3;
  localparam int           SR_LOCK     = 7;
  localparam logic         LVL_RST     = 1'b1;
  localparam logic         LOCK_RST    = 1'b0;

  // erase decoding: 4 KByte sectors, 32 KByte blocks
  localparam int           SECTOR_SHIFT = 12;
  localparam int           BLOCK_SHIFT  = 15;
  localparam int           SECTOR_W     = ADDR_W - SECTOR_SHIFT;
  localparam int           BLOCK_W      = ADDR_W - BLOCK_SHIFT;

  // receive buffer
  localparam logic [1:0]   BUF_DEPTH   = 2'h2;

  // synchronised pin group
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic si;
    logic hold_n;
    logic wp_n;
  } sfshp_pins_t;

  localparam sfshp_pins_t PINS_IDLE = '{sck: 1'b0, cs_n: 1'b1, si: 1'b0,
                                        hold_n: 1'b1, wp_n: 1'b1};

  // frame sequencing
  typedef enum logic [1:0] {FR_IDLE, FR_ACTIVE, FR_PAUSED} sfshp_frame_t;

  // one received byte with its frame position
  typedef struct packed {
    logic        first;
    logic [7:0]  data;
  } sfshp_rx_t;

  localparam int RX_W = $bits(sfshp_rx_t);

endpackage

// File: verilog/sfshp_buf.sv
// two-entry valid/ready buffer for received bytes
`timescale 1ns/1ps
module sfshp_buf
  import sfshp_pkg::*;
#(
  parameter int W = RX_W
)(
  // clock, reset, enable
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         en,
  // filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  // all buffer state
  typedef struct packed {
    logic [1:0][W-1:0] mem;   // entries
    logic              wr;    // write slot
    logic              rd;    // read slot
    logic [1:0]        cnt;   // fill level
  } sfshp_bufst_t;

  sfshp_bufst_t s_r;
  sfshp_bufst_t s_nxt;
  logic         push;
  logic         pop;

  // honest flags
  assign in_ready  = (s_r.cnt != BUF_DEPTH);
  assign out_valid = (s_r.cnt != 2'h0);
  assign out_data  = s_r.mem[s_r.rd];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // next state
  always_comb
  begin
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.mem[s_r.wr] = in_data;
      s_nxt.wr          = ~s_r.wr;
    end
    if (pop)
      s_nxt.rd = ~s_r.rd;
    if (push & ~pop)
      s_nxt.cnt = s_r.cnt + 2'h1;
    else if (pop & ~push)
      s_nxt.cnt = s_r.cnt - 2'h1;
  end

  // state register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_r <= '0;
    else if (en)
      s_r <= s_nxt;
  end

endmodule // sfshp_buf

// File: verilog/sfshp_core.sv
// serial flash interface front end: framing, hold, status write guard
`timescale 1ns/1ps
module sfshp_core
  import sfshp_pkg::*;
#(
  parameter logic [7:0] STATUS_WRITE_OP = 8'h01  // status_write_cmd opcode
)(
  // clock and reset
  input  wire logic               CORE_CLK,
  input  wire logic               RST,
  input  wire logic               CLK_EN,
  // serial pins
  input  wire logic               SCK,
  input  wire logic               CS_N,
  input  wire logic               SI,
  output logic                    SO_O,
  output logic                    SO_OE,
  input  wire logic               HOLD_N,
  input  wire logic               WP_N,
  // received byte stream
  output logic                    RX_VALID,
  input  wire logic               RX_READY,
  output sfshp_rx_t               RX_DATA,
  // byte to send
  input  wire logic [BYTE_W-1:0]  TX_DATA,
  output logic                    TX_TAKE,
  // status and decode
  output logic [BYTE_W-1:0]       STATUS,
  output logic                    SELECTED,
  output logic                    PAUSED,
  output logic                    OVERRUN,
  output logic [SECTOR_W-1:0]     ERASE_SECTOR,
  output logic [BLOCK_W-1:0]      ERASE_BLOCK
);

  // all state of the front end
  typedef struct packed {
    sfshp_pins_t       sync1;      // first sync stage
    sfshp_pins_t       sync2;      // second sync stage
    logic              sck_prev;   // clock level last cycle
    logic              cs_prev;    // select level last cycle
    sfshp_frame_t      frame;      // frame state
    logic              armed;      // rising edge seen since last shift out
    logic [2:0]        bit_cnt;    // bit within byte
    logic [2:0]        byte_cnt;   // byte within frame
    logic [7:0]        shift_in;   // input shifter
    logic [7:0]        shift_out;  // output shifter
    logic [7:0]        opcode;     // first byte of frame
    logic [ADDR_W-1:0] addr;       // address bytes
    logic              so;         // output bit
    logic              lock;       // protect_lock_bit
    logic              lvl_hi;     // protect_level_hi
    logic              lvl_lo;     // protect_level_lo
    logic              overrun;    // byte lost to full buffer
    logic              push;       // byte ready for buffer
    sfshp_rx_t         push_data;  // that byte
  } sfshp_core_t;

  localparam sfshp_core_t CORE_RST = '{sync1: PINS_IDLE, sync2: PINS_IDLE,
    cs_prev: 1'b1, frame: FR_IDLE, lock: LOCK_RST, lvl_hi: LVL_RST,
    lvl_lo: LVL_RST, default: '0};

  sfshp_core_t s_r;
  sfshp_core_t s_nxt;
  sfshp_pins_t p;            // synchronised pins
  logic        rise;         // clock rising edge
  logic        fall;         // clock falling edge
  logic        cs_fall;      // select falling edge
  logic [7:0]  byte_in;      // byte completing on this edge
  logic        byte_done;    // eighth bit captured
  logic        wr_try;       // status write data byte arrives
  logic        wr_allow;     // status write permitted
  logic        buf_ready;    // buffer can take a byte
  logic        tx_take;      // send byte loaded

  // edge finders on the second sync stage only
  assign p        = s_r.sync2;
  assign rise     = p.sck & ~s_r.sck_prev;
  assign fall     = ~p.sck & s_r.sck_prev;
  assign cs_fall  = s_r.cs_prev & ~p.cs_n;
  assign byte_in  = {s_r.shift_in[6:0], p.si};
  assign byte_done = (s_r.frame == FR_ACTIVE) & ~p.cs_n & rise & (s_r.bit_cnt == BIT_LAST);
  assign wr_try   = byte_done & (s_r.byte_cnt == BC_DATA1) & (s_r.opcode == STATUS_WRITE_OP);
  assign wr_allow = p.wp_n | ~s_r.lock;

  // next state
  always_comb
  begin
    s_nxt          = s_r;
    tx_take        = 1'b0;
    s_nxt.sync1    = '{sck: SCK, cs_n: CS_N, si: SI, hold_n: HOLD_N, wp_n: WP_N};
    s_nxt.sync2    = s_r.sync1;
    s_nxt.sck_prev = p.sck;
    s_nxt.cs_prev  = p.cs_n;
    s_nxt.push     = 1'b0;
    // lost byte flag, cleared per frame; a loss wins over the clear
    if (cs_fall)
      s_nxt.overrun = 1'b0;
    if (s_r.push & ~buf_ready)
      s_nxt.overrun = 1'b1;
    case (s_r.frame)
      FR_IDLE:
      begin
        if (cs_fall)
        begin
          s_nxt.frame     = FR_ACTIVE;
          s_nxt.bit_cnt   = BIT_FIRST;
          s_nxt.byte_cnt  = BC_OPCODE;
          s_nxt.armed     = 1'b0;
          s_nxt.so        = TX_DATA[7];
          s_nxt.shift_out = {TX_DATA[6:0], 1'b0};
          tx_take         = 1'b1;
        end
      end
      FR_ACTIVE:
      begin
        if (p.cs_n)
          s_nxt.frame = FR_IDLE;      // frame closed
        else
        begin
          if (rise)
          begin
            s_nxt.shift_in = byte_in;
            s_nxt.bit_cnt  = s_r.bit_cnt + 3'h1;
            s_nxt.armed    = 1'b1;
          end
          if (byte_done)
          begin
            s_nxt.push      = 1'b1;
            s_nxt.push_data = '{first: (s_r.byte_cnt == BC_OPCODE), data: byte_in};
            if (s_r.byte_cnt == BC_OPCODE)
              s_nxt.opcode = byte_in;
            else if (s_r.byte_cnt <= BC_ADDR_END)
              s_nxt.addr = {s_r.addr[ADDR_W-BYTE_W-1:0], byte_in};
            if (s_r.byte_cnt != BC_MAX)
              s_nxt.byte_cnt = s_r.byte_cnt + 3'h1;
          end
          if (wr_try & wr_allow)
          begin
            s_nxt.lock   = byte_in[SR_LOCK];
            s_nxt.lvl_hi = byte_in[SR_LVL_HI];
            s_nxt.lvl_lo = byte_in[SR_LVL_LO];
          end
          // shift out after a falling edge
          if (fall & s_r.armed)
          begin
            s_nxt.armed = 1'b0;
            if (s_r.bit_cnt == BIT_FIRST)
            begin
              s_nxt.so        = TX_DATA[7];
              s_nxt.shift_out = {TX_DATA[6:0], 1'b0};
              tx_take         = 1'b1;
            end
            else
            begin
              s_nxt.so        = s_r.shift_out[7];
              s_nxt.shift_out = {s_r.shift_out[6:0], 1'b0};
            end
          end
          // pause at clock low, edge above kept
          if (~p.sck & ~p.hold_n)
            s_nxt.frame = FR_PAUSED;
        end
      end
      FR_PAUSED:
      begin
        if (p.cs_n)
          s_nxt.frame = FR_IDLE;
        // resume only on hold high, clock low
        else if (~p.sck & p.hold_n)
          s_nxt.frame = FR_ACTIVE;
      end
      default:
        s_nxt.frame = FR_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      s_r <= CORE_RST;
    else if (CLK_EN)
      s_r <= s_nxt;
  end

  // receive buffer between shifter and user
  sfshp_buf #(.W(RX_W)) u_buf (
    .clk       (CORE_CLK),
    .rst       (RST),
    .en        (CLK_EN),
    .in_valid  (s_r.push),
    .in_ready  (buf_ready),
    .in_data   (s_r.push_data),
    .out_valid (RX_VALID),
    .out_ready (RX_READY),
    .out_data  (RX_DATA)
  );

  // status image, other bits read zero
  always_comb
  begin
    STATUS            = '0;
    STATUS[SR_LOCK]   = s_r.lock;
    STATUS[SR_LVL_HI] = s_r.lvl_hi;
    STATUS[SR_LVL_LO] = s_r.lvl_lo;
  end

  // drive output only in an active frame
  assign SO_OE        = (s_r.frame == FR_ACTIVE);
  assign SO_O         = s_r.so;
  assign TX_TAKE      = tx_take & CLK_EN;
  assign SELECTED     = (s_r.frame != FR_IDLE);
  assign PAUSED       = (s_r.frame == FR_PAUSED);
  assign OVERRUN      = s_r.overrun;
  // sector and block of the address
  assign ERASE_SECTOR = s_r.addr[ADDR_W-1:SECTOR_SHIFT];
  assign ERASE_BLOCK  = s_r.addr[ADDR_W-1:BLOCK_SHIFT];

  AST_CAPTURE: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CLK_EN & rise & (s_r.frame == FR_ACTIVE) & ~p.cs_n)
      |=> (s_r.shift_in == {$past(s_r.shift_in[6:0]), $past(p.si)}))
    else $error("input bit not captured on rising edge");

  AST_SO_EDGE: assert property (@(posedge CORE_CLK) disable iff (RST)
    !$stable(s_r.so) |-> $past(fall | cs_fall))
    else $error("output bit changed without falling edge");

  AST_FRAME_OPEN: assert property (@(posedge CORE_CLK) disable iff (RST)
    ($past(s_r.frame) == FR_IDLE) & (s_r.frame == FR_ACTIVE) |-> $past(cs_fall))
    else $error("frame opened without select fall");

  AST_PAUSE_ENTRY: assert property (@(posedge CORE_CLK) disable iff (RST)
    (s_r.frame == FR_PAUSED) & ($past(s_r.frame) == FR_ACTIVE)
      |-> $past(~p.sck & ~p.hold_n & ~p.cs_n))
    else $error("pause entered at wrong moment");

  AST_PAUSE_EXIT: assert property (@(posedge CORE_CLK) disable iff (RST)
    ($past(s_r.frame) == FR_PAUSED) & (s_r.frame == FR_ACTIVE) |-> $past(~p.sck & p.hold_n))
    else $error("pause left at wrong moment");

  AST_PAUSE_KEEP: assert property (@(posedge CORE_CLK) disable iff (RST)
    (s_r.frame == FR_PAUSED) & ~p.hold_n & ~p.cs_n & CLK_EN
      |=> (s_r.frame == FR_PAUSED) & $stable(s_r.bit_cnt) & $stable(s_r.byte_cnt))
    else $error("pause or bit position lost while hold low");

  AST_PAUSE_ABORT: assert property (@(posedge CORE_CLK) disable iff (RST)
    (s_r.frame == FR_PAUSED) & p.cs_n & CLK_EN |=> (s_r.frame == FR_IDLE) ##1 !SO_OE)
    else $error("deselect in pause did not abandon");

  AST_PAUSE_RELEASE: assert property (@(posedge CORE_CLK) disable iff (RST)
    CLK_EN & (s_r.frame != FR_IDLE) & ~p.cs_n & ~p.sck & ~p.hold_n |=> !SO_OE)
    else $error("output driven while paused");

  AST_DESEL_RELEASE: assert property (@(posedge CORE_CLK) disable iff (RST)
    CLK_EN & p.cs_n |=> !SELECTED & !SO_OE)
    else $error("output driven or frame kept while deselected");

  AST_LOCK_REFUSE: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CLK_EN & wr_try & ~p.wp_n & s_r.lock)
      |=> $stable(s_r.lock) & $stable(s_r.lvl_hi) & $stable(s_r.lvl_lo))
    else $error("locked status write changed bits");

  AST_WP_HIGH: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CLK_EN & wr_try & p.wp_n)
      |=> (STATUS[SR_LOCK] == $past(byte_in[SR_LOCK]))
        & (STATUS[SR_LVL_HI] == $past(byte_in[SR_LVL_HI])))
    else $error("status write refused with protect high");

  AST_NO_STRAY_WRITE: assert property (@(posedge CORE_CLK) disable iff (RST)
    !$stable(s_r.lock) |-> $past(wr_try & wr_allow))
    else $error("lock bit changed outside a permitted write");

endmodule // sfshp_core

// File: test/sfshp_host.sv
// host-side model of the serial bus master
`timescale 1ns/1ps
module sfshp_host
  import sfshp_pkg::*;
(
  // pacing clock
  input  wire logic CORE_CLK,
  // pins toward the device
  output logic      SCK,
  output logic      CS_N,
  output logic      SI,
  output logic      HOLD_N,
  // device output pin
  input  wire logic SO_O,
  input  wire logic SO_OE
);
  logic mode3;                          // idle clock level high
  wire  so_line = SO_OE ? SO_O : 1'bz;  // released pin floats
  // pins idle, device deselected
  initial
  begin
    SCK = 1'b0;
    CS_N = 1'b1;
    SI = 1'b0;
    HOLD_N = 1'b1;
    mode3 = 1'b0;
  end
  // half period of four core cycles
  task automatic tick(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask
  // idle level by mode, then select
  task automatic sel(input logic m3);
    mode3 = m3;
    SCK <= m3;
    tick(4);
    // select stays low for the frame
    CS_N <= 1'b0;
    tick(4);
  endtask
  // back to idle level, deselect, data line scrambled
  task automatic desel();
    SCK <= mode3;
    tick(4);
    CS_N <= 1'b1;
    SI <= ~SI;
    tick(4);
  endtask
  // one bit: data set in low phase, output sampled at rise
  task automatic send_bit(input logic b, output logic r);
    SCK <= 1'b0;
    SI <= b;
    tick(4);
    SCK <= 1'b1;
    r = so_line;
    tick(4);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
      send_bit(b[i], r[i]);
  endtask
  // clock move with data noise
  task automatic clk_to(input logic v);
    SCK <= v;
    SI <= ~SI;
    tick(4);
  endtask
  // resume needs hold high with select low
  task automatic set_hold(input logic v);
    HOLD_N <= v;
  endtask
endmodule // sfshp_host

// File: test/test_sfshp_core.sv
// self-checking bench of the serial flash front end
`timescale 1ns/1ps
module test_sfshp_core;
  import sfshp_pkg::*;
  localparam logic [7:0] SW_OP = 8'h01;  // status write opcode
  logic                CORE_CLK, RST, CLK_EN, RX_READY, WP_N;
  logic                SCK, CS_N, SI, HOLD_N, SO_O, SO_OE;
  logic                RX_VALID, TX_TAKE, SELECTED, PAUSED, OVERRUN;
  sfshp_rx_t           RX_DATA;
  logic [7:0]          TX_DATA, STATUS, r;
  logic [SECTOR_W-1:0] ERASE_SECTOR;
  logic [BLOCK_W-1:0]  ERASE_BLOCK;
  int                  n_fail, total_checks;
  int                  n_take;          // load pulses seen
  sfshp_rx_t           rxq[$];          // bytes taken from the stream
  sfshp_core #(.STATUS_WRITE_OP(SW_OP)) uut (
    .CORE_CLK     (CORE_CLK),
    .RST          (RST),
    .CLK_EN       (CLK_EN),
    .SCK          (SCK),
    .CS_N         (CS_N),
    .SI           (SI),
    .SO_O         (SO_O),
    .SO_OE        (SO_OE),
    .HOLD_N       (HOLD_N),
    .WP_N         (WP_N),
    .RX_VALID     (RX_VALID),
    .RX_READY     (RX_READY),
    .RX_DATA      (RX_DATA),
    .TX_DATA      (TX_DATA),
    .TX_TAKE      (TX_TAKE),
    .STATUS       (STATUS),
    .SELECTED     (SELECTED),
    .PAUSED       (PAUSED),
    .OVERRUN      (OVERRUN),
    .ERASE_SECTOR (ERASE_SECTOR),
    .ERASE_BLOCK  (ERASE_BLOCK)
  );
  sfshp_host host (
    .CORE_CLK (CORE_CLK),
    .SCK      (SCK),
    .CS_N     (CS_N),
    .SI       (SI),
    .HOLD_N   (HOLD_N),
    .SO_O     (SO_O),
    .SO_OE    (SO_OE)
  );
  // core clock
  initial
  begin
    CORE_CLK = 1'b0;
    forever #50 CORE_CLK = ~CORE_CLK;
  end
  // collect accepted bytes; step the reply byte per load
  always @(posedge CORE_CLK)
  begin
    if (RX_VALID && RX_READY)
      rxq.push_back(RX_DATA);
    if (CS_N)
      TX_DATA <= 8'h96;
    else if (TX_TAKE)
      TX_DATA <= TX_DATA + 8'h11;
    if (TX_TAKE)
      n_take <= n_take + 1;
  end
  // verdict and end of run
  task automatic print_verdict();
    if (n_fail == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // compare and count
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bounded wait for one byte, then compare it
  task automatic chk_rx(input logic f, input logic [7:0] d);
    int n;
    n = 0;
    while (rxq.size() == 0 && n < 20)
    begin
      host.tick(1);
      n++;
    end
    if (rxq.size() == 0)
    begin
      n_fail++;
      $display("unexpected rx count expected 1 seen 0");
      print_verdict();
    end
    chk("rx byte", {f, d}, rxq.pop_front());
  endtask
  // idle checks: reset values, deselected and hold ignored
  task automatic t_idle();
    chk("status", 8'h0C, STATUS);
    host.send_byte(8'hFF, r);
    chk("rx count", 0, rxq.size());
    chk("so enable", 0, SO_OE);
    host.set_hold(1'b0);
    host.tick(5);
    chk("paused", 0, PAUSED);
    host.set_hold(1'b1);
    host.tick(4);
  endtask
  // mode 0 frame: opcode and address in, reply bytes out
  task automatic t_frame();
    logic [31:0] f;
    logic [23:0] a;
    int          t0;
    f = 32'h52123456;
    a = f[23:0];
    t0 = n_take;
    host.sel(1'b0);
    for (int k = 0; k < 4; k++)
    begin
      host.send_byte(f[31-8*k -: 8], r);
      chk("so byte", 8'h96 + 8'h11 * k, r);
      chk_rx(k == 0, f[31-8*k -: 8]);
    end
    host.desel();
    chk("tx take count", 5, n_take - t0);
    chk("sector", a[23:12], ERASE_SECTOR);
    chk("block", a[23:15], ERASE_BLOCK);
  endtask
  // receiver stalls: buffer fills, third byte lost, then drained
  task automatic t_stall();
    RX_READY <= 1'b0;
    host.sel(1'b1);
    host.send_byte(8'hA1, r);
    host.send_byte(8'hB2, r);
    host.send_byte(8'hC3, r);
    host.desel();
    chk("overrun", 1, OVERRUN);
    chk("rx valid", 1, RX_VALID);
    RX_READY <= 1'b1;
    host.tick(4);
    chk("rx valid", 0, RX_VALID);
    chk("rx count", 2, rxq.size());
    chk_rx(1'b1, 8'hA1);
    chk_rx(1'b0, 8'hB2);
  endtask
  // status writes under every protect and lock combination
  task automatic t_status();
    logic [4:0]  wpv;
    logic [39:0] dat, ex;
    wpv = 5'b00101;
    dat = 40'hFF_00_04_88_00;
    ex = 40'h8C_8C_04_88_88;
    for (int i = 0; i < 5; i++)
    begin
      WP_N <= wpv[i];
      host.sel(i[0]);
      host.send_byte(SW_OP, r);
      host.send_byte(dat[39-8*i -: 8], r);
      host.desel();
      chk("status", ex[39-8*i -: 8], STATUS);
    end
    WP_N <= 1'b1;
    chk("overrun", 0, OVERRUN);
    rxq.delete();
  endtask
  // clock enable low: pins toggle, front end frozen
  task automatic t_freeze();
    CLK_EN <= 1'b0;
    host.sel(1'b0);
    host.send_byte(8'h5A, r);
    chk("selected", 0, SELECTED);
    chk("so enable", 0, SO_OE);
    chk("tx take", 0, TX_TAKE);
    host.desel();
    CLK_EN <= 1'b1;
    host.tick(4);
    chk("selected", 0, SELECTED);
    chk("rx count", 0, rxq.size());
  endtask
  // hold mid-byte: late entry, noise ignored, byte intact
  task automatic t_hold();
    logic [7:0] b;
    b = 8'hC6;
    host.sel(1'b0);
    for (int i = 7; i > 3; i--)
      host.send_bit(b[i], r[i]);
    host.set_hold(1'b0);
    host.tick(4);
    chk("paused", 0, PAUSED);
    host.clk_to(1'b0);
    host.tick(1);
    chk("paused", 1, PAUSED);
    chk("so enable", 0, SO_OE);
    host.clk_to(1'b1);
    host.clk_to(1'b0);
    host.clk_to(1'b1);
    host.clk_to(1'b0);
    chk("paused", 1, PAUSED);
    host.set_hold(1'b1);
    host.tick(5);
    chk("paused", 0, PAUSED);
    for (int i = 3; i >= 0; i--)
      host.send_bit(b[i], r[i]);
    chk_rx(1'b1, b);
    host.desel();
  endtask
  // deselect while paused abandons the frame
  task automatic t_abandon();
    host.sel(1'b1);
    for (int i = 0; i < 3; i++)
      host.send_bit(1'b1, r[i]);
    host.clk_to(1'b0);
    host.set_hold(1'b0);
    host.tick(5);
    chk("paused", 1, PAUSED);
    host.desel();
    chk("selected", 0, SELECTED);
    chk("paused", 0, PAUSED);
    host.set_hold(1'b1);
    host.sel(1'b0);
    host.send_byte(8'h3C, r);
    host.desel();
    chk_rx(1'b1, 8'h3C);
    chk("rx count", 0, rxq.size());
  endtask
  // hang guard
  initial
  begin
    #2000000;
    n_fail++;
    print_verdict();
  end
  // main sequence
  initial
  begin
    n_fail = 0;
    total_checks = 0;
    RST = 1'b1;
    CLK_EN = 1'b1;
    RX_READY = 1'b1;
    WP_N = 1'b1;
    repeat (6) @(posedge CORE_CLK);
    RST <= 1'b0;
    host.tick(2);
    t_idle();
    t_frame();
    t_stall();
    t_status();
    t_hold();
    t_abandon();
    t_freeze();
    print_verdict();
  end
endmodule // test_sfshp_core
